// ===== inc/usb_irq_pkg.sv
// constants for the usb interrupt aggregator: register map, bit layout, timing
// assumes an apb slave at 50 mhz; all offsets are byte addresses of 32-bit words
package usb_irq_pkg;
  // register byte offsets
  localparam logic [7:0] STATUS_FLAG_OFS   = 8'h00;
  localparam logic [7:0] STATUS_ENABLE_OFS = 8'h04;
  localparam logic [7:0] ERROR_FLAG_OFS    = 8'h08;
  localparam logic [7:0] ERROR_ENABLE_OFS  = 8'h0C;
  localparam logic [7:0] REQUEST_OFS       = 8'h10;
  localparam logic [7:0] CONTROL_OFS       = 8'h14;
  // status flag positions
  localparam int STAT_W         = 8;
  localparam int ERR_W          = 8;
  localparam int BIT_RESET      = 0;
  localparam int BIT_ERROR      = 1;
  localparam int BIT_ACTIVITY   = 2;
  localparam int BIT_TRANSFER   = 3;
  localparam int BIT_IDLE       = 4;
  localparam int BIT_STALL      = 5;
  localparam int BIT_SOF        = 6;
  // control register fields
  localparam int CTRL_SUSPEND   = 0;
  localparam int CTRL_PULLUP    = 1;
  // reset values
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] ERR_RESET  = 8'h00;
  // timing
  localparam int CLK_HZ          = 50_000_000;
  localparam int IDLE_TIME_US    = 3000;
  localparam int IDLE_CYCLES     = IDLE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int WAKE_SYNC_CYCLES = 4;
endpackage : usb_irq_pkg

// ===== hw/usb_interrupt_aggregator.sv
// usb interrupt aggregator: two-level flag/enable logic with apb access
// assumes sie events as one-cycle pulses synchronous to sys_clk
// limitation: a bus idle flag is raised once per quiet spell, not every cycle
// writes land at the edge where pready is sampled high, reads are captured one edge earlier, when pready rises
`timescale 1ns/100ps
`default_nettype none
module usb_interrupt_aggregator #(
  parameter int IDLE_LIMIT = usb_irq_pkg::IDLE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [7:0]  status_event,
  input  wire logic [7:0]  error_event,
  input  wire logic        bus_traffic,
  output var  logic        usb_request_flag,
  output var  logic        irq,
  output var  logic        suspend_control,
  output var  logic        pullup_enable
);
  localparam logic [7:0] ERRB = 8'h01 << usb_irq_pkg::BIT_ERROR;
  localparam logic [7:0] ACTB = 8'h01 << usb_irq_pkg::BIT_ACTIVITY;
  localparam logic [7:0] IDLB = 8'h01 << usb_irq_pkg::BIT_IDLE;

  logic [7:0]  status_flag_q, status_flag_d;
  logic [7:0]  status_enable_q;
  logic [7:0]  error_flag_q, error_flag_d;
  logic [7:0]  error_enable_q;
  logic        request_q;
  logic [1:0]  ctrl_q;
  logic [31:0] idle_cnt_q;
  logic        armed_q;
  logic [2:0]  sync_cnt_q;
  logic [31:0] prdata_q;
  logic        pready_q;

  // apb decode; one wait state, write applied with pready at the access end
  wire acc      = psel & penable & ~pready_q;
  wire wr       = psel & penable & pready_q & pwrite;
  wire rd       = acc & ~pwrite;
  wire sel_sf   = paddr == usb_irq_pkg::STATUS_FLAG_OFS;
  wire sel_se   = paddr == usb_irq_pkg::STATUS_ENABLE_OFS;
  wire sel_ef   = paddr == usb_irq_pkg::ERROR_FLAG_OFS;
  wire sel_ee   = paddr == usb_irq_pkg::ERROR_ENABLE_OFS;
  wire sel_rq   = paddr == usb_irq_pkg::REQUEST_OFS;
  wire sel_ct   = paddr == usb_irq_pkg::CONTROL_OFS;
  wire mapped   = sel_sf | sel_se | sel_ef | sel_ee | sel_rq | sel_ct;

  // activity clear blocked while suspended or synchronising after wake
  wire act_clr_ok = ~ctrl_q[usb_irq_pkg::CTRL_SUSPEND] & (sync_cnt_q == 3'd0);

  // idle detection: count quiet cycles
  wire idle_hit  = (idle_cnt_q == 32'(IDLE_LIMIT)) & ~bus_traffic;
  // activity only once per resume, and only after idle flagged
  wire act_event = bus_traffic & armed_q;

  // error level: enabled errors fold into summary
  wire err_any = |(error_flag_q & error_enable_q);

  // activity bit kept against a write while its clear is blocked
  wire [7:0] sf_keep  = act_clr_ok ? 8'h00 : ACTB;

  // next flag values; hardware set wins over any clear
  always_comb begin
    status_flag_d = status_flag_q;
    if (wr & sel_sf) begin
      status_flag_d = (pwdata[7:0] | (status_flag_q & sf_keep));
    end
    status_flag_d = status_flag_d | (status_event & ~(ACTB | IDLB | ERRB));
    if (act_event) begin
      status_flag_d = status_flag_d | ACTB;
    end
    if (idle_hit) begin
      status_flag_d = status_flag_d | IDLB;
    end
    if (err_any) begin
      status_flag_d = status_flag_d | ERRB;
    end
  end

  always_comb begin
    error_flag_d = (wr & sel_ef) ? pwdata[7:0] : error_flag_q;
    error_flag_d = error_flag_d | error_event;
  end

  // read mux
  wire [31:0] rd_val =
    sel_sf ? {24'h0000_00, status_flag_q}   :
    sel_se ? {24'h0000_00, status_enable_q} :
    sel_ef ? {24'h0000_00, error_flag_q}    :
    sel_ee ? {24'h0000_00, error_enable_q}  :
    sel_rq ? {31'h0000_0000, request_q}     :
    sel_ct ? {30'h0000_0000, ctrl_q}        : 32'h0000_0000;

  // request flag: any enabled status flag; software clear loses to a set
  wire req_set = |(status_flag_q & status_enable_q);

  // registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_flag_q   <= usb_irq_pkg::STAT_RESET;
      error_flag_q    <= usb_irq_pkg::ERR_RESET;
      status_enable_q <= 8'h00;
      error_enable_q  <= 8'h00;
      ctrl_q          <= 2'b00;
    end else begin
      status_flag_q <= status_flag_d;
      error_flag_q  <= error_flag_d;
      if (wr & sel_se) status_enable_q <= pwdata[7:0];
      if (wr & sel_ee) error_enable_q  <= pwdata[7:0];
      if (wr & sel_ct) ctrl_q          <= pwdata[1:0];
    end
  end

  // single request flag, set wins over software clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      request_q <= 1'b0;
    end else if (req_set) begin
      request_q <= 1'b1;
    end else if (wr & sel_rq) begin
      request_q <= pwdata[0];
    end
  end

  // idle counter and activity arming
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_q <= 32'h0000_0000;
      armed_q    <= 1'b0;
    end else begin
      if (bus_traffic) idle_cnt_q <= 32'h0000_0000;
      else if (idle_cnt_q != 32'(IDLE_LIMIT + 1)) idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
      if (idle_hit) armed_q <= 1'b1;
      else if (act_event) armed_q <= 1'b0;
    end
  end

  // wake synchroniser delay after suspend drops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_cnt_q <= 3'd0;
    end else if (ctrl_q[usb_irq_pkg::CTRL_SUSPEND]) begin
      sync_cnt_q <= 3'(usb_irq_pkg::WAKE_SYNC_CYCLES);
    end else if (sync_cnt_q != 3'd0) begin
      sync_cnt_q <= sync_cnt_q - 3'd1;
    end
  end

  // apb answer and outputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q         <= 32'h0000_0000;
      pready_q         <= 1'b0;
      pslverr          <= 1'b0;
      usb_request_flag <= 1'b0;
      irq              <= 1'b0;
      suspend_control  <= 1'b0;
      pullup_enable    <= 1'b0;
    end else begin
      pready_q         <= acc;
      pslverr          <= acc & ~mapped;
      prdata_q         <= rd ? rd_val : 32'h0000_0000;
      usb_request_flag <= request_q | req_set;
      irq              <= request_q | req_set;
      suspend_control  <= ctrl_q[usb_irq_pkg::CTRL_SUSPEND];
      pullup_enable    <= ctrl_q[usb_irq_pkg::CTRL_PULLUP];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;

  // checks
  err_summary_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    err_any |=> status_flag_q[usb_irq_pkg::BIT_ERROR])
    else $error("error summary not set");
  flag_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (status_flag_q[usb_irq_pkg::BIT_IDLE] && !(wr && sel_sf))
      |=> status_flag_q[usb_irq_pkg::BIT_IDLE])
    else $error("idle flag dropped without write");
  err_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    error_event[0] |=> error_flag_q[0])
    else $error("error flag late");
  req_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req_set |=> usb_request_flag)
    else $error("request flag missing");
  act_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (status_flag_q[usb_irq_pkg::BIT_ACTIVITY] && ctrl_q[usb_irq_pkg::CTRL_SUSPEND])
      |=> status_flag_q[usb_irq_pkg::BIT_ACTIVITY])
    else $error("activity cleared while suspended");
  act_once_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    act_event |=> !armed_q)
    else $error("activity armed twice");
  idle_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    idle_hit |=> status_flag_q[usb_irq_pkg::BIT_IDLE] && armed_q)
    else $error("idle flag not raised");
  poll_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (status_event[3] && status_enable_q == 8'h00) |=> status_flag_q[3])
    else $error("disabled flag not set");

  // irq output mirrors the request flag
  req_one_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req_set
      |=> irq)
    else $error("irq missing");

  // request flag holds until software clears it
  req_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (request_q && !(wr && sel_rq))
      |=> request_q)
    else $error("request flag dropped");

  // request output low when nothing pending
  req_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!req_set && !request_q)
      |=> !usb_request_flag)
    else $error("request flag spurious");

  // stall event reaches its status bit
  stat_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    status_event[usb_irq_pkg::BIT_STALL]
      |=> status_flag_q[usb_irq_pkg::BIT_STALL])
    else $error("status flag not set");

  // software write sets a status flag
  sw_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr && sel_sf && pwdata[usb_irq_pkg::BIT_SOF])
      |=> status_flag_q[usb_irq_pkg::BIT_SOF])
    else $error("software set of status lost");

  // software write sets an error flag
  err_sw_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr && sel_ef && pwdata[0])
      |=> error_flag_q[0])
    else $error("software set of error lost");

  // summary flag sticky until written
  sum_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (status_flag_q[usb_irq_pkg::BIT_ERROR] && !(wr && sel_sf))
      |=> status_flag_q[usb_irq_pkg::BIT_ERROR])
    else $error("summary flag dropped");

  // cleared activity stays clear while disarmed
  act_rearm_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!status_flag_q[usb_irq_pkg::BIT_ACTIVITY] && !armed_q && !(wr && sel_sf))
      |=> !status_flag_q[usb_irq_pkg::BIT_ACTIVITY])
    else $error("activity set without idle");

  // armed traffic raises the activity flag
  act_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    act_event
      |=> status_flag_q[usb_irq_pkg::BIT_ACTIVITY])
    else $error("activity flag missing");

  // activity kept during the wake window
  sync_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (status_flag_q[usb_irq_pkg::BIT_ACTIVITY] && sync_cnt_q != 3'd0)
      |=> status_flag_q[usb_irq_pkg::BIT_ACTIVITY])
    else $error("activity cleared during wake");

  // wake window loaded when suspend drops
  wake_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(ctrl_q[usb_irq_pkg::CTRL_SUSPEND])
      |-> sync_cnt_q == 3'(usb_irq_pkg::WAKE_SYNC_CYCLES))
    else $error("wake window not loaded");

  // pull-up output follows its control bit
  pullup_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_q[usb_irq_pkg::CTRL_PULLUP]
      |=> pullup_enable)
    else $error("pull-up dropped");

  // suspend output follows its control bit
  suspend_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_q[usb_irq_pkg::CTRL_SUSPEND]
      |=> suspend_control)
    else $error("suspend output missing");

  // traffic restarts the quiet count
  quiet_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_traffic
      |=> idle_cnt_q == 32'h0000_0000)
    else $error("quiet count not cleared");

  // one idle event per quiet spell
  idle_once_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    idle_hit
      |=> !idle_hit)
    else $error("idle event repeated");

  // pready is a single-cycle pulse
  apb_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pready
      |=> !pready)
    else $error("pready stuck high");

  // unmapped access answered with an error
  apb_err_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (acc && !mapped)
      |=> (pslverr && pready))
    else $error("no error response");

  // read data zero outside read answers
  rdata_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !rd
      |=> prdata == 32'h0000_0000)
    else $error("read data not zero");

  // per-bit checks of both flag levels
  for (genvar g = 0; g < usb_irq_pkg::ERR_W; g++) begin : bit_chk
    err_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (error_flag_q[g] && !(wr && sel_ef))
        |=> error_flag_q[g])
      else $error("error flag dropped");

    err_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr && sel_ef && !pwdata[g] && !error_event[g])
        |=> !error_flag_q[g])
      else $error("error flag not cleared");

    err_poll_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (error_event[g] && !error_enable_q[g])
        |=> error_flag_q[g])
      else $error("disabled error not set");

    err_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (error_flag_q[g] && error_enable_q[g])
        |=> status_flag_q[usb_irq_pkg::BIT_ERROR])
      else $error("enabled error not summarised");

    stat_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (status_flag_q[g] && status_enable_q[g])
        |=> usb_request_flag)
      else $error("enabled status not requested");
  end
endmodule : usb_interrupt_aggregator
`default_nettype wire

// ===== testbench/usb_host_model.sv
// usb host model: alternating bus traffic, silent on request
// assumes the aggregator's clock and reset
`timescale 1ns/100ps
`default_nettype none
module usb_host_model (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic quiet,
  output var  logic bus_traffic
);
  // busy every other cycle; silence lets the device see suspend
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) bus_traffic <= 1'b0;
    else        bus_traffic <= !quiet && !bus_traffic;
  end
endmodule : usb_host_model
`default_nettype wire

// ===== testbench/tb_usb_interrupt_aggregator.sv
// self-checking bench for the usb interrupt aggregator
// assumes one wait state apb slave and a short idle limit
`timescale 1ns/100ps
`default_nettype none
module tb_usb_interrupt_aggregator;
  localparam int IDLE_N = 20;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_t;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic        bus_traffic, quiet, usb_request_flag, irq, suspend_control, pullup_enable;
  logic [7:0]  paddr, status_event, error_event;
  logic [31:0] pwdata, prdata, rd;
  int          miscompares, comparisons, i;
  // rows: address, write value, read back, error response
  row_t        rows [4] = '{'{8'h04, 32'h0000_1234, 32'h0000_0034, 1'b0},
                            '{8'h0c, 32'h0000_00a5, 32'h0000_00a5, 1'b0},
                            '{8'h14, 32'h0000_0002, 32'h0000_0002, 1'b0},
                            '{8'h20, 32'h0000_0001, 32'h0000_0000, 1'b1}};

  usb_interrupt_aggregator #(.IDLE_LIMIT(IDLE_N)) usb_interrupt_aggregator_inst (.sys_clk,
    .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .status_event, .error_event, .bus_traffic, .usb_request_flag, .irq, .suspend_control,
    .pullup_enable);
  usb_host_model usb_host_model_inst (.sys_clk, .rst_n, .quiet, .bus_traffic);

  // 50 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk

  task automatic pulse(input logic [7:0] s, input logic [7:0] e);
    status_event <= s;
    error_event <= e;
    @(posedge sys_clk);
    status_event <= 8'h00;
    error_event <= 8'h00;
    @(posedge sys_clk);
  endtask : pulse

  task automatic stop_test;
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  // watchdog
  initial begin
    repeat (4000) @(posedge sys_clk);
    miscompares++;
    stop_test();
  end

  // main sequence
  initial begin
    {rst_n, psel, penable, pwrite, quiet} = '0;
    {paddr, status_event, error_event, pwdata} = '0;
    {miscompares, comparisons} = '0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk(irq, 1'b0);
    chk(pullup_enable, 1'b0);
    rdchk(8'h00, 32'h0000_0000);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].r);
      chk(er, rows[i].e);
    end
    pulse(8'h08, 8'h00);
    rdchk(8'h00, 32'h0000_0008);
    chk(irq, 1'b0);
    apb(1'b1, 8'h04, 32'h0000_0008);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b1);
    chk(usb_request_flag, 1'b1);
    rdchk(8'h00, 32'h0000_0008);
    apb(1'b1, 8'h00, 32'h0000_0000);
    apb(1'b1, 8'h10, 32'h0000_0000);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    pulse(8'h00, 8'h02);
    rdchk(8'h08, 32'h0000_0002);
    rdchk(8'h00, 32'h0000_0000);
    pulse(8'h00, 8'h04);
    rdchk(8'h00, 32'h0000_0002);
    apb(1'b1, 8'h08, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0040);
    rdchk(8'h00, 32'h0000_0040);
    apb(1'b1, 8'h00, 32'h0000_0000);
    quiet <= 1'b1;
    repeat (IDLE_N - 8) @(posedge sys_clk);
    rdchk(8'h00, 32'h0000_0000);
    repeat (10) @(posedge sys_clk);
    rdchk(8'h00, 32'h0000_0010);
    apb(1'b1, 8'h14, 32'h0000_0003);
    @(posedge sys_clk);
    chk(pullup_enable, 1'b1);
    chk(suspend_control, 1'b1);
    quiet <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rdchk(8'h00, 32'h0000_0014);
    apb(1'b1, 8'h00, 32'h0000_0010);
    rdchk(8'h00, 32'h0000_0014);
    apb(1'b1, 8'h14, 32'h0000_0002);
    for (i = 0; i < 10; i++) begin
      apb(1'b0, 8'h00, 32'h0000_0000);
      if (rd[2] === 1'b1) apb(1'b1, 8'h00, 32'h0000_0010);
    end
    chk(suspend_control, 1'b0);
    repeat (10) @(posedge sys_clk);
    rdchk(8'h00, 32'h0000_0010);
    // reset in mid-run clears flags and outputs
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk(usb_request_flag, 1'b0);
    chk(pullup_enable, 1'b0);
    rdchk(8'h00, 32'h0000_0000);
    rdchk(8'h14, 32'h0000_0000);
    stop_test();
  end
endmodule : tb_usb_interrupt_aggregator
`default_nettype wire
